// >>> hw/fc_cfg.svh
// Constants for the flash program and erase controller and its core-side end
`ifndef FC_CFG_SVH
`define FC_CFG_SVH

// Key codes, in the order software writes them
`define FC_KEY_FIRST      8'ha5
`define FC_KEY_SECOND     8'hf1

// Program-store control bit positions
`define FC_PROGRAM_STORE_CONTROL_WE_BIT   0
`define FC_PROGRAM_STORE_CONTROL_EE_BIT   1
`define FC_PROGRAM_STORE_CONTROL_RESET    2'h0

// Memory geometry
`define FC_ADDR_W         16
`define FC_FLASH_AW       11
`define FC_FLASH_BYTES    2048
`define FC_PAGE_AW        9
`define FC_PAGE_BYTES     512
`define FC_EXTERNAL_DATA_RAM_AW        9
`define FC_EXTERNAL_DATA_RAM_BYTES     512
`define FC_ERASED_BYTE    8'hff

// Timing: clock period and byte program time in ns, count derived (rounded up)
`define FC_CLK_NS         100
`define FC_PROG_NS        2000
`define FC_PROG_CYC       ((`FC_PROG_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_CNT_W          10

// Core-side register map (byte offsets on AHB-Lite)
`define FC_REG_ADDR       8'h00
`define FC_REG_WDATA      8'h04
`define FC_REG_CMD        8'h08
`define FC_REG_STATUS     8'h0c
`define FC_REG_RDATA      8'h10

// Status register bit positions
`define FC_ST_BUSY_BIT    0
`define FC_ST_STALL_BIT   1
`define FC_ST_LOCKOUT_BIT 2
`define FC_ST_WE_BIT      3
`define FC_ST_EE_BIT      4

`endif

// >>> hw/fc_core_port.sv
// Core-side end: AHB-Lite registers that issue operations to the flash controller
`timescale 1ns/1ps
`include "fc_cfg.svh"

module fc_core_port
   import fc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   fc_link_if.core          link
);

   // ==========================================================
   // AHB address phase capture
   logic                  dph_wr_r;
   logic [7:0]            dph_addr_r;
   logic [31:0]           hrdata_r;
   logic [`FC_ADDR_W-1:0] addr_r;
   logic [7:0]            wdata_r;
   logic                  req_r;
   fc_op_t                op_r;
   logic [7:0]            rdata_r;

   wire       aph     = hsel && hready && htrans[1];
   wire       wr_addr = dph_wr_r && (dph_addr_r == `FC_REG_ADDR);
   wire       wr_data = dph_wr_r && (dph_addr_r == `FC_REG_WDATA);
   wire       wr_cmd  = dph_wr_r && (dph_addr_r == `FC_REG_CMD) && !req_r;
   wire       done    = req_r && link.ack;
   wire       rd_op   = (op_r == FC_OP_DRD) || (op_r == FC_OP_CRD);
   wire [4:0] status  = {link.program_store_control[`FC_PROGRAM_STORE_CONTROL_EE_BIT], link.program_store_control[`FC_PROGRAM_STORE_CONTROL_WE_BIT],
                         link.lockout, link.stall, req_r};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_r   <= 1'b0;
         dph_addr_r <= 8'h00;
      end else begin
         dph_wr_r   <= aph && hwrite;
         dph_addr_r <= aph ? haddr[7:0] : dph_addr_r;
      end
   end

   // ==========================================================
   // Operation registers and request hand-off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_r  <= '0;
         wdata_r <= 8'h00;
         op_r    <= FC_OP_KEY;
         req_r   <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         if (wr_addr) begin
            addr_r <= hwdata[`FC_ADDR_W-1:0];
         end
         if (wr_data) begin
            wdata_r <= hwdata[7:0];
         end
         if (wr_cmd) begin
            op_r  <= fc_op_t'(hwdata[2:0]);
            req_r <= 1'b1;
         end else if (done) begin
            req_r <= 1'b0;
         end
         if (done && rd_op) begin
            rdata_r <= link.rdata;
         end
      end
   end

   // ==========================================================
   // AHB read mux and response
   wire [31:0] rd_mux = (haddr[7:0] == `FC_REG_ADDR)   ? {16'h0000, addr_r} :
                        (haddr[7:0] == `FC_REG_WDATA)  ? {24'h000000, wdata_r} :
                        (haddr[7:0] == `FC_REG_CMD)    ? {29'h00000000, op_r} :
                        (haddr[7:0] == `FC_REG_STATUS) ? {27'h0000000, status} :
                        (haddr[7:0] == `FC_REG_RDATA)  ? {24'h000000, rdata_r} :
                                                         32'h00000000;

   // Read word taken at the address phase and held through the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h00000000;
      end else begin
         hrdata_r <= (aph && !hwrite) ? rd_mux : 32'h00000000;
      end
   end

   assign hrdata     = hrdata_r;
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign link.req   = req_r;
   assign link.op    = op_r;
   assign link.addr  = addr_r;
   assign link.wdata = wdata_r;

endmodule // fc_core_port

// >>> hw/fc_flash_ctrl.sv
// Flash program/erase controller with key lock, flash array and external data RAM
//
// Summary of operation
// - Data-space write programs one flash byte
// - Programming only clears bits to zero
// - Erase sets whole 512-byte page to 0xFF
// - Hardware times every write and erase
// - Core stalled during write or erase (here only the status stall bit is set; hreadyout stays high)
// - Keys 0xA5 then 0xF1 before each operation
// - Wrong or reversed key locks out until reset
// - Operation without keys locks out until reset
// - Key state relocks after every operation
// - Write enable steers writes to flash
// - Both enables plus keys erase page
// - Write enable alone plus keys programs byte
// - Software erases first, masks interrupts
// - Software clears write enable when done
// - Data reads go to RAM, code reads flash
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "fc_cfg.svh"

module fc_flash_ctrl
   import fc_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   fc_link_if.dev    link
);

   // ==========================================================
   // Storage
   logic [7:0]              flash_mem [0:`FC_FLASH_BYTES-1];
   logic [7:0]              external_data_ram_mem  [0:`FC_EXTERNAL_DATA_RAM_BYTES-1];

   // ==========================================================
   // State
   fc_state_t               state_r;
   fc_state_t               state_nxt;
   fc_key_t                 key_r;
   fc_key_t                 key_nxt;
   logic                    lockout_r;
   logic                    lockout_nxt;
   logic [1:0]              program_store_control_r;
   logic [1:0]              program_store_control_nxt;
   logic [`FC_CNT_W-1:0]    cnt_r;
   logic [`FC_CNT_W-1:0]    cnt_nxt;
   logic [`FC_FLASH_AW-1:0] faddr_r;
   logic [7:0]              fdata_r;
   logic                    ack_r;
   logic                    ack_nxt;
   logic [7:0]              rdata_r;

   // ==========================================================
   // Request decode
   wire                     take      = link.req && !ack_r && (state_r == FC_ST_IDLE);
   wire                     is_key    = take && (link.op == FC_OP_KEY);
   wire                     is_ctl    = take && (link.op == FC_OP_CTL);
   wire                     is_dwr    = take && (link.op == FC_OP_DWR);
   wire                     is_drd    = take && (link.op == FC_OP_DRD);
   wire                     is_crd    = take && (link.op == FC_OP_CRD);
   wire                     we_bit    = program_store_control_r[`FC_PROGRAM_STORE_CONTROL_WE_BIT];
   wire                     ee_bit    = program_store_control_r[`FC_PROGRAM_STORE_CONTROL_EE_BIT];
   wire                     unlocked  = (key_r == FC_KEY_OPEN) && !lockout_r;
   wire                     to_external_data_ram   = is_dwr && !we_bit;
   wire                     to_flash  = is_dwr && we_bit;
   wire                     fl_start  = to_flash && unlocked;
   wire                     fl_reject = to_flash && !unlocked;
   wire [`FC_FLASH_AW-1:0]  in_faddr  = link.addr[`FC_FLASH_AW-1:0];
   wire [`FC_EXTERNAL_DATA_RAM_AW-1:0]   in_xaddr  = link.addr[`FC_EXTERNAL_DATA_RAM_AW-1:0];
   wire                     key_good1 = (key_r == FC_KEY_LOCKED) && (link.wdata == `FC_KEY_FIRST);
   wire                     key_good2 = (key_r == FC_KEY_HALF) && (link.wdata == `FC_KEY_SECOND);
   wire                     prog_last = (cnt_r == `FC_CNT_W'(`FC_PROG_CYC - 1));
   wire                     erase_last = (cnt_r == `FC_CNT_W'(`FC_PAGE_BYTES - 1));
   wire [`FC_FLASH_AW-1:0]  erase_addr = {faddr_r[`FC_FLASH_AW-1:`FC_PAGE_AW],
                                          cnt_r[`FC_PAGE_AW-1:0]};

   // ==========================================================
   // Key tracker and lockout
   always_comb begin
      key_nxt     = key_r;
      lockout_nxt = lockout_r;
      if (is_key) begin
         if (lockout_r) begin
            key_nxt = FC_KEY_LOCKED;
         end else if (key_good1) begin
            key_nxt = FC_KEY_HALF;
         end else if (key_good2) begin
            key_nxt = FC_KEY_OPEN;
         end else begin
            key_nxt     = FC_KEY_LOCKED;
            lockout_nxt = 1'b1;
         end
      end else if (fl_reject) begin
         key_nxt     = FC_KEY_LOCKED;
         lockout_nxt = 1'b1;
      end else if (fl_start) begin
         key_nxt = FC_KEY_LOCKED;
      end
   end

   // ==========================================================
   // Program-store control
   always_comb begin
      program_store_control_nxt = program_store_control_r;
      if (is_ctl) begin
         program_store_control_nxt = link.wdata[1:0];
      end
   end

   // ==========================================================
   // Operation sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      ack_nxt   = 1'b0;
      case (state_r)
         FC_ST_IDLE: begin
            cnt_nxt = '0;
            if (fl_start && ee_bit) begin
               state_nxt = FC_ST_ERASE;
            end else if (fl_start) begin
               state_nxt = FC_ST_PROG;
            end else if (take) begin
               ack_nxt = 1'b1;
            end
         end
         FC_ST_PROG: begin
            cnt_nxt = cnt_r + `FC_CNT_W'(1);
            if (prog_last) begin
               state_nxt = FC_ST_IDLE;
               ack_nxt   = 1'b1;
            end
         end
         FC_ST_ERASE: begin
            cnt_nxt = cnt_r + `FC_CNT_W'(1);
            if (erase_last) begin
               state_nxt = FC_ST_IDLE;
               ack_nxt   = 1'b1;
            end
         end
         default: begin
            state_nxt = FC_ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r   <= FC_ST_IDLE;
         key_r     <= FC_KEY_LOCKED;
         lockout_r <= 1'b0;
         program_store_control_r   <= `FC_PROGRAM_STORE_CONTROL_RESET;
         cnt_r     <= '0;
         ack_r     <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         key_r     <= key_nxt;
         lockout_r <= lockout_nxt;
         program_store_control_r   <= program_store_control_nxt;
         cnt_r     <= cnt_nxt;
         ack_r     <= ack_nxt;
      end
   end

   // Captured target of a flash operation
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         faddr_r <= '0;
         fdata_r <= 8'h00;
      end else if (fl_start) begin
         faddr_r <= in_faddr;
         fdata_r <= link.wdata;
      end
   end

   // ==========================================================
   // Read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= 8'h00;
      end else if (is_drd) begin
         rdata_r <= external_data_ram_mem[in_xaddr];
      end else if (is_crd) begin
         rdata_r <= flash_mem[in_faddr];
      end
   end

   // ==========================================================
   // Memory arrays (no reset; contents are undefined until written)
   always_ff @(posedge hclk) begin
      if (state_r == FC_ST_PROG && prog_last) begin
         flash_mem[faddr_r] <= flash_mem[faddr_r] & fdata_r;
      end else if (state_r == FC_ST_ERASE) begin
         flash_mem[erase_addr] <= `FC_ERASED_BYTE;
      end
   end

   always_ff @(posedge hclk) begin
      // write enable clear goes to RAM
      if (to_external_data_ram) begin
         external_data_ram_mem[in_xaddr] <= link.wdata;
      end
   end

   // ==========================================================
   // Outputs
   assign link.ack     = ack_r;
   assign link.rdata   = rdata_r;
   assign link.stall   = (state_r != FC_ST_IDLE);
   assign link.lockout = lockout_r;
   assign link.program_store_control   = program_store_control_r;

endmodule // fc_flash_ctrl

// >>> hw/fc_link_if.sv
// Link between the core-side end and the flash controller
`timescale 1ns/1ps
`include "fc_cfg.svh"

interface fc_link_if;
   import fc_pkg::*;

   logic                  req;
   fc_op_t                op;
   logic [`FC_ADDR_W-1:0] addr;
   logic [7:0]            wdata;
   logic                  ack;
   logic [7:0]            rdata;
   logic                  stall;
   logic                  lockout;
   logic [1:0]            program_store_control;

   modport dev (
      input  req,
      input  op,
      input  addr,
      input  wdata,
      output ack,
      output rdata,
      output stall,
      output lockout,
      output program_store_control
   );

   modport core (
      output req,
      output op,
      output addr,
      output wdata,
      input  ack,
      input  rdata,
      input  stall,
      input  lockout,
      input  program_store_control
   );

endinterface

// >>> hw/fc_pkg.sv
// Types shared by the flash controller and its core-side end
package fc_pkg;

   typedef enum logic [2:0] {
      FC_OP_KEY,
      FC_OP_CTL,
      FC_OP_DWR,
      FC_OP_DRD,
      FC_OP_CRD
   } fc_op_t;

   typedef enum logic [1:0] {
      FC_KEY_LOCKED,
      FC_KEY_HALF,
      FC_KEY_OPEN
   } fc_key_t;

   typedef enum logic [1:0] {
      FC_ST_IDLE,
      FC_ST_PROG,
      FC_ST_ERASE
   } fc_state_t;

endpackage

// >>> verif/fc_link_checker.sv
// Assertions on the link between the core-side end and the flash controller
`timescale 1ns/1ps
`include "fc_cfg.svh"

module fc_link_checker
   import fc_pkg::*;
(
   input wire logic                  hclk,
   input wire logic                  hresetn,
   input wire logic                  req,
   input wire logic [2:0]            op,
   input wire logic [`FC_ADDR_W-1:0] addr,
   input wire logic [7:0]            wdata,
   input wire logic                  ack,
   input wire logic [7:0]            rdata,
   input wire logic                  stall,
   input wire logic                  lockout,
   input wire logic [1:0]            program_store_control
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // =========================
   // Helper logic
   logic [9:0] stall_cnt_r;
   logic [9:0] stall_cnt_nxt;
   wire        take     = req && !ack && !stall;
   wire        flash_wr = take && op == FC_OP_DWR && program_store_control[0];
   wire [1:0]  ctl_bits = wdata[1:0];

   assign stall_cnt_nxt = stall ? stall_cnt_r + 10'h1 : 10'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stall_cnt_r <= 10'h0;
      end else begin
         stall_cnt_r <= stall_cnt_nxt;
      end
   end

   // =========================
   // Assertions
   AST_ACK_PULSE: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   AST_LOCK_STICKY: assert property (lockout |=> lockout)
      else $error("lockout cleared without reset");
   AST_STALL_ENDS_ACK: assert property ($fell(stall) |-> ack)
      else $error("stall ended without ack");
   AST_OP_LENGTH: assert property ($fell(stall) |-> (program_store_control[1] ?
      stall_cnt_r == 10'h200 : stall_cnt_r == 10'h014))
      else $error("flash operation length wrong");
   AST_SIMPLE_ACK: assert property (take && op != FC_OP_DWR |=> ack && !stall)
      else $error("simple operation not answered in one cycle");
   AST_RAM_WRITE: assert property (take && op == FC_OP_DWR && !program_store_control[0] |=> ack && !stall)
      else $error("data write with write enable clear stalled");
   AST_REFUSED: assert property (flash_wr && lockout |=> ack && !stall)
      else $error("flash write ran while locked out");
   AST_BAD_KEY: assert property (take && op == FC_OP_KEY &&
      !(wdata inside {`FC_KEY_FIRST, `FC_KEY_SECOND}) |=> lockout)
      else $error("wrong key did not lock out");
   AST_CTL_WRITE: assert property (take && op == FC_OP_CTL |=> program_store_control == $past(ctl_bits))
      else $error("control write not applied");
   AST_PROGRAM_STORE_CONTROL_HOLD: assert property (!(take && op == FC_OP_CTL) |=> $stable(program_store_control))
      else $error("control bits changed on their own");
   AST_REQ_HOLD: assert property (req && !ack |=> req)
      else $error("request dropped before its answer");
   AST_RDATA_HOLD: assert property (!(take && (op == FC_OP_DRD || op == FC_OP_CRD)) |=> $stable(rdata))
      else $error("read data changed without a read");
endmodule // fc_link_checker

// >>> verif/flash_program_erase_control_tb_top.sv
// Testbench for the flash program and erase controller
`timescale 1ns/1ps
`include "fc_cfg.svh"

module flash_program_erase_control_tb_top
   import fc_pkg::*;
   ;
   logic        hclk      = 1'b0;
   logic        hresetn   = 1'b0;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [1:0]  htrans    = 2'h0;
   logic [2:0]  hsize     = 3'h2;
   logic [31:0] haddr     = 32'h0;
   logic [31:0] hwdata    = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] rd;
   int          stalls;
   int          failures  = 0;
   int          n_tests   = 0;
   logic [7:0]  ktab [4][2] = '{'{8'ha5, 8'hf1}, '{8'hf1, 8'ha5}, '{8'ha5, 8'h12}, '{8'h5a, 8'hf1}};
   logic [15:0] pg [3]      = '{16'h0200, 16'h0234, 16'h03ff};

   always #50 hclk = ~hclk;

   // =========================
   // Design and checker
   fc_link_if fc_link_if_inst ();
   fc_flash_ctrl fc_flash_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .link(fc_link_if_inst.dev));
   fc_core_port fc_core_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(fc_link_if_inst.core));
   fc_link_checker fc_link_checker_inst (.hclk(hclk), .hresetn(hresetn),
      .req(fc_link_if_inst.req), .op(fc_link_if_inst.op), .addr(fc_link_if_inst.addr),
      .wdata(fc_link_if_inst.wdata), .ack(fc_link_if_inst.ack), .rdata(fc_link_if_inst.rdata),
      .stall(fc_link_if_inst.stall), .lockout(fc_link_if_inst.lockout),
      .program_store_control(fc_link_if_inst.program_store_control));

   // =========================
   // Tasks
   task automatic close_out();
      $display("Checks %0d, failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 100) begin
            failures++;
            close_out();
         end
         @(posedge hclk);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic rdreg(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask

   task automatic op(input fc_op_t o, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      stalls = 0;
      xfer(1'b1, `FC_REG_ADDR, {16'h0, a});
      xfer(1'b1, `FC_REG_WDATA, {24'h0, d});
      xfer(1'b1, `FC_REG_CMD, {29'h0, o});
      do begin
         rdreg(`FC_REG_STATUS);
         stalls += int'(rd[`FC_ST_STALL_BIT] === 1'b1);
         n++;
      end while (rd[`FC_ST_BUSY_BIT] !== 1'b0 && n < 1000);
      if (n >= 1000) begin
         failures++;
         close_out();
      end
   endtask

   task automatic keys();
      op(FC_OP_KEY, 16'h0, `FC_KEY_FIRST);
      op(FC_OP_KEY, 16'h0, `FC_KEY_SECOND);
   endtask

   task automatic rdf(input logic [15:0] a);
      op(FC_OP_CRD, a, 8'h0);
      rdreg(`FC_REG_RDATA);
   endtask

   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask

   // =========================
   // Main sequence
   initial begin
      do_reset();
      rdreg(`FC_REG_STATUS);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      xfer(1'b1, 8'h20, 32'hffffffff);
      rdreg(8'h20);
      chk(rd, 32'h0);
      op(FC_OP_CTL, 16'h0, 8'h00);
      keys();
      op(FC_OP_DWR, 16'h0234, 8'h5a);
      chk(stalls, 32'h0);
      op(FC_OP_CTL, 16'h0, 8'h03);
      rdreg(`FC_REG_STATUS);
      chk(rd, 32'h18);
      op(FC_OP_DWR, 16'h0234, 8'h00);
      chk(32'(stalls != 0), 32'h1);
      for (int i = 0; i < 3; i++) begin
         rdf(pg[i]);
         chk(rd, 32'hff);
      end
      op(FC_OP_DRD, 16'h0234, 8'h0);
      rdreg(`FC_REG_RDATA);
      chk(rd, 32'h5a);
      op(FC_OP_CTL, 16'h0, 8'h01);
      keys();
      op(FC_OP_DWR, 16'h0234, 8'h3c);
      rdf(16'h0234);
      chk(rd, 32'h3c);
      keys();
      op(FC_OP_DWR, 16'h0234, 8'hf0);
      rdf(16'h0234);
      chk(rd, 32'h30);
      op(FC_OP_DWR, 16'h0235, 8'h00);
      rdreg(`FC_REG_STATUS);
      chk(rd, 32'h0c);
      keys();
      op(FC_OP_DWR, 16'h0235, 8'h00);
      rdf(16'h0235);
      chk(rd, 32'hff);
      op(FC_OP_CTL, 16'h0, 8'h02);
      op(FC_OP_DWR, 16'h0236, 8'h77);
      chk(stalls, 32'h0);
      op(FC_OP_DRD, 16'h0236, 8'h0);
      rdreg(`FC_REG_RDATA);
      chk(rd, 32'h77);
      rdf(16'h0236);
      chk(rd, 32'hff);
      for (int i = 0; i < 4; i++) begin
         do_reset();
         op(FC_OP_CTL, 16'h0, 8'h01);
         op(FC_OP_KEY, 16'h0, ktab[i][0]);
         op(FC_OP_KEY, 16'h0, ktab[i][1]);
         op(FC_OP_DWR, 16'h0300 + 16'(i), 8'h00);
         rdf(16'h0300 + 16'(i));
         chk(rd, (i == 0) ? 32'h0 : 32'hff);
         rdreg(`FC_REG_STATUS);
         chk(rd, (i == 0) ? 32'h08 : 32'h0c);
      end
      close_out();
   end
endmodule // flash_program_erase_control_tb_top
